/* File: warm_reset_consts.vh */
// constants for the warm reset sequencer
`ifndef WARM_RESET_CONSTS_VH
`define WARM_RESET_CONSTS_VH
`define CLOCK_HZ            25000000
`define HALF_CLOCK_PERIODS  1024
`define SEQ_CYCLES          (`HALF_CLOCK_PERIODS / 2)
`define SEQ_CNT_W           10
`define SEQ_LAST            10'h1ff
`define START_ADDR          24'h000000
`define CFG_EMULATION_BIT   0
`define CFG_MODE_A_BIT      1
`define CFG_CLK_LO          13
`define CFG_CLK_HI          15
`define CFG_RESET_VAL       16'hffff
`define PIN_SYNC_RST        1'b0
`define CFG_SYNC_RST        1'b1
`define RST_INTERNAL        1'b1
`define RST_PULLUP          1'b1
`define RST_RESET_OUTPUT_PIN_N        1'b0
`define RST_CFG_BIT         1'b1
`define RST_CLK_CFG         3'h7
`endif

/* File: sync2.v */
// two flip-flop synchroniser for one level
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
   parameter RESET_VAL = 1'b1
) (
   input  wire i_clock,
   input  wire i_reset_n,
   input  wire i_async,
   output reg  o_sync
);
   reg stage1;
   // first stage feeds only the second
   always @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         stage1 <= RESET_VAL;
         o_sync <= RESET_VAL;
      end else begin
         stage1 <= i_async;
         o_sync <= stage1;
      end
   end
endmodule // sync2
`default_nettype wire

/* File: warm_reset_sequencer.v */
// warm reset sequencer: pin handling, sequence timer, start-up config capture
`timescale 1ns/1ps
`default_nettype none
`include "warm_reset_consts.vh"

// Behaviour
// - at warm reset start pending hold states are dropped and a running access is finished first.
// - during the internal sequence the device drives its own reset input pin low.
// - reset ends only after the sequence time has passed and the reset pin then reads high.
// - on leaving reset fetch starts at the fixed start address zero.
// - the reset output pin stays asserted after reset until end-of-init is executed.
// - general purpose pins stay inactive after reset until software enables them.
// - pull-ups on the start-up config port are enabled during reset.
// - the internal sequence lasts exactly 1024 half clock periods.
// - emulation, mode-a and clock config bits load continuously while internal reset is active.
module warm_reset_sequencer (
   input  wire        i_clock,
   input  wire        i_reset_n,
   input  wire        i_reset_input_pin,
   input  wire        i_access_busy,
   input  wire        i_end_of_init_instruction,
   input  wire        i_io_enable_write,
   input  wire [15:0] i_startup_config_port,
   output reg         o_reset_input_pin_out,
   output reg         o_reset_input_pin_oe,
   output reg         o_reset_output_pin_n,
   output reg         o_internal_reset,
   output reg         o_cancel_holds,
   output reg         o_fetch_start,
   output reg  [23:0] o_fetch_addr,
   output reg         o_io_active,
   output reg         o_config_pullup_en,
   output reg         o_emulation_mode_bit,
   output reg         o_mode_bit_a,
   output reg  [2:0]  o_clock_config
);
   localparam S_RUN   = 3'h0;
   localparam S_DRAIN = 3'h1;
   localparam S_SEQ   = 3'h2;
   localparam S_WAIT  = 3'h3;
   localparam S_INIT  = 3'h4;

   // synchronised pins, decoded phases, state and the sequence counter
   wire        pin_sync;
   wire [15:0] cfg_sync;
   wire        next_in_reset;
   wire        warm_start;
   wire        reset_leaving;
   reg  [2:0]  state;
   reg  [2:0]  next_state;
   reg  [`SEQ_CNT_W-1:0] count;

   // reset pin through two flops; it reads asserted until it has really been sampled high
   sync2 #(.RESET_VAL(`PIN_SYNC_RST)) u_pin_sync (
      .i_clock   (i_clock),
      .i_reset_n (i_reset_n),
      .i_async   (i_reset_input_pin),
      .o_sync    (pin_sync)
   );

   // config port lines each pass two flops before capture
   genvar g;
   generate
      for (g = 0; g < 16; g = g + 1) begin : g_cfg
         sync2 #(.RESET_VAL(`CFG_SYNC_RST)) u_cfg_sync (
            .i_clock   (i_clock),
            .i_reset_n (i_reset_n),
            .i_async   (i_startup_config_port[g]),
            .o_sync    (cfg_sync[g])
         );
      end
   endgenerate

   // sequencing; while driving the pin low our own drive masks the outside source
   always @* begin
      next_state = state;
      case (state)
         // a low pin from the board starts a warm reset
         S_RUN:   if (!pin_sync) next_state = S_DRAIN;
         // hold the sequence until a running internal access has completed
         S_DRAIN: if (!i_access_busy) next_state = S_SEQ;
         // count out the fixed sequence with the pin held low
         S_SEQ:   if (count == `SEQ_LAST) next_state = S_WAIT;
         // reset ends only once the released pin reads high
         S_WAIT:  if (pin_sync) next_state = S_INIT;
         // a fresh request restarts the sequence; end-of-init counts only here
         S_INIT:  if (!pin_sync) next_state = S_DRAIN;
                  else if (i_end_of_init_instruction) next_state = S_RUN;
         // unused codes fall back to running
         default: next_state = S_RUN;
      endcase
   end

   // decoded phases of the next state; registering them keeps every output a flop
   assign next_in_reset = (next_state == S_DRAIN) || (next_state == S_SEQ) ||
                          (next_state == S_WAIT);
   // a request while running or in an unfinished init phase both start a sequence
   assign warm_start    = (next_state == S_DRAIN) &&
                          ((state == S_RUN) || (state == S_INIT));
   // leaving the pin wait is the one place where reset ends
   assign reset_leaving = (state == S_WAIT) && (next_state == S_INIT);

   // state register; power-up parks in the pin wait, so the core leaves that reset
   // through the same fetch and end-of-init path as after a warm reset
   always @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state <= S_WAIT;
      end else begin
         state <= next_state;
      end
   end

   // 1024 half periods equal 512 clock cycles; the count restarts on every entry,
   // so a restarted sequence is never shortened by a stale value
   always @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         count <= {`SEQ_CNT_W{1'b0}};
      end else if (state == S_SEQ) begin
         count <= count + 10'h001;
      end else begin
         count <= {`SEQ_CNT_W{1'b0}};
      end
   end

   // open-drain reset pin: the data bit stays low and only the enable moves, so the
   // line is never driven high against the board's reset source
   always @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_reset_input_pin_out <= 1'b0;
         o_reset_input_pin_oe  <= 1'b0;
      end else begin
         o_reset_input_pin_out <= 1'b0;
         o_reset_input_pin_oe  <= (next_state == S_SEQ);
      end
   end

   // one-cycle cancel of pending hold states at every sequence start; a request that
   // cuts an init phase short cancels them again
   always @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_cancel_holds <= 1'b0;
      end else begin
         o_cancel_holds <= warm_start;
      end
   end

   // internal reset spans drain, sequence and pin wait; it drops only after the
   // released pin has been seen high
   always @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_internal_reset <= `RST_INTERNAL;
      end else begin
         o_internal_reset <= next_in_reset;
      end
   end

   // config pull-ups share the internal reset window, so an open port line reads high
   // and a strapped one reads low while the start-up bits are captured
   always @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_config_pullup_en <= `RST_PULLUP;
      end else begin
         o_config_pullup_en <= next_in_reset;
      end
   end

   // fetch request for one cycle as the core leaves reset; it lines up with the
   // falling internal reset so the first fetch never sees a core still in reset
   always @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_fetch_start <= 1'b0;
      end else begin
         o_fetch_start <= reset_leaving;
      end
   end

   // the fetch address is held in a flop so it stands clean with the request
   always @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_fetch_addr <= `START_ADDR;
      end else if (reset_leaving) begin
         o_fetch_addr <= `START_ADDR;
      end
   end

   // reset output asserted from sequence start until end-of-init has run; external
   // logic thus stays in reset through the whole init phase
   always @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_reset_output_pin_n <= `RST_RESET_OUTPUT_PIN_N;
      end else if (next_state == S_RUN) begin
         o_reset_output_pin_n <= 1'b1;
      end else begin
         o_reset_output_pin_n <= 1'b0;
      end
   end

   // io pins stay inactive through reset; software turns them on afterwards, and a
   // write during reset is dropped rather than remembered
   always @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_io_active <= 1'b0;
      end else if (next_in_reset) begin
         o_io_active <= 1'b0;
      end else if (i_io_enable_write) begin
         o_io_active <= 1'b1;
      end
   end

   // config bits follow the port while internal reset is active and act at once; the
   // capture uses the registered reset flag, so the port is read one cycle longer
   always @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_emulation_mode_bit <= `RST_CFG_BIT;
         o_mode_bit_a         <= `RST_CFG_BIT;
         o_clock_config       <= `RST_CLK_CFG;
      end else if (o_internal_reset) begin
         o_emulation_mode_bit <= cfg_sync[`CFG_EMULATION_BIT];
         o_mode_bit_a         <= cfg_sync[`CFG_MODE_A_BIT];
         o_clock_config       <= cfg_sync[`CFG_CLK_HI:`CFG_CLK_LO];
      end
   end
endmodule // warm_reset_sequencer
`default_nettype wire

/* File: reset_source_model.sv */
// board reset source on the open-drain reset line
`timescale 1ns/1ps
`default_nettype none
module reset_source_model (
   input  wire logic i_hold_low,
   input  wire logic i_oe,
   input  wire logic i_out,
   output wire logic o_pin
);
   // board pull-up wins unless a party pulls the line low
   assign o_pin = !(i_hold_low || (i_oe && !i_out));
endmodule // reset_source_model
`default_nettype wire

/* File: warm_reset_sequencer_sva.sv */
// port checker for the warm reset sequencer
`timescale 1ns/1ps
`default_nettype none
module warm_reset_sequencer_sva (
   input wire logic        i_clock,
   input wire logic        i_reset_n,
   input wire logic        i_end_of_init_instruction,
   input wire logic        o_reset_input_pin_oe,
   input wire logic        o_reset_output_pin_n,
   input wire logic        o_internal_reset,
   input wire logic        o_cancel_holds,
   input wire logic        o_fetch_start,
   input wire logic [23:0] o_fetch_addr,
   input wire logic        o_io_active,
   input wire logic        o_config_pullup_en
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_reset_n);
   logic [10:0] oe_cycles;
   // 11 bits so an overrun past the sequence length is still caught
   always_ff @(posedge i_clock or negedge i_reset_n)
      if (!i_reset_n) oe_cycles <= 11'h000;
      else oe_cycles <= o_reset_input_pin_oe ? oe_cycles + 11'h001 : 11'h000;
   a_pin_drive_low: assert property (
      o_reset_input_pin_oe |-> o_internal_reset && !o_reset_output_pin_n) else $error("pin oe");
   a_cancel_in_rst: assert property (
      o_cancel_holds |-> o_internal_reset && !o_reset_output_pin_n) else $error("cancel");
   a_seq_length: assert property (
      $fell(o_reset_input_pin_oe) |-> oe_cycles == 11'h200) else $error("seq length");
   a_wait_for_pin: assert property (
      $fell(o_reset_input_pin_oe) |-> o_internal_reset) else $error("early end");
   a_fetch_zero: assert property (
      o_fetch_start |-> o_fetch_addr == 24'h000000 ##1 !o_fetch_start) else $error("fetch");
   a_reset_output_pin_hold: assert property (
      !o_reset_output_pin_n && !i_end_of_init_instruction |=> !o_reset_output_pin_n)
      else $error("rst out");
   a_io_quiet: assert property (
      o_internal_reset |-> !o_io_active) else $error("io");
   a_pullup_rst: assert property (
      o_config_pullup_en == o_internal_reset) else $error("pullup");
endmodule // warm_reset_sequencer_sva
bind warm_reset_sequencer warm_reset_sequencer_sva warm_reset_sequencer_sva_inst (.*);
`default_nettype wire

/* File: tb.sv */
// self-checking bench for the warm reset sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic i_clock = 1'b0, i_reset_n = 1'b0, hold_low = 1'b0, i_access_busy = 1'b0;
   logic i_end_of_init_instruction = 1'b0, i_io_enable_write = 1'b0;
   logic [15:0] i_startup_config_port = 16'hffff;
   wire logic i_reset_input_pin, o_reset_input_pin_out, o_reset_input_pin_oe, o_fetch_start;
   wire logic o_reset_output_pin_n, o_internal_reset, o_cancel_holds, o_io_active;
   wire logic o_config_pullup_en, o_emulation_mode_bit, o_mode_bit_a;
   wire logic [23:0] o_fetch_addr;
   wire logic [2:0] o_clock_config;
   int err_total = 0, cmp_count = 0, cycles = 0, n, k, d, pulses;
   always #20 i_clock = ~i_clock;
   warm_reset_sequencer warm_reset_sequencer_inst (.*);
   reset_source_model reset_source_model_inst (.i_hold_low(hold_low),
      .i_oe(o_reset_input_pin_oe), .i_out(o_reset_input_pin_out), .o_pin(i_reset_input_pin));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         $display("BAD %0t %h %h", $time, got, exp);
         err_total++;
      end
   endtask
   task automatic final_report();
      $display("compares %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // hang guard: two sequences need well under this
   always @(posedge i_clock) if (++cycles > 4000) begin
      err_total++;
      final_report();
   end
   // wait for the fetch pulse that ends reset, then check what stands with it
   task automatic wait_fetch(input logic [15:0] cfg);
      n = 0;
      while (!o_fetch_start && n < 20) begin
         @(posedge i_clock);
         n++;
      end
      chk(o_fetch_start, 1);
      chk(o_fetch_addr, 0);
      chk(o_internal_reset, 0);
      chk(o_config_pullup_en, 0);
      chk({o_clock_config, o_mode_bit_a, o_emulation_mode_bit}, {cfg[15:13], cfg[1:0]});
      chk(o_reset_output_pin_n, 0);
      chk(o_io_active, 0);
   endtask
   // software enables the pins, then end-of-init releases the reset output
   task automatic end_init();
      i_io_enable_write <= 1'b1;
      @(posedge i_clock);
      i_io_enable_write <= 1'b0;
      i_end_of_init_instruction <= 1'b1;
      @(posedge i_clock);
      i_end_of_init_instruction <= 1'b0;
      repeat (2) @(posedge i_clock);
      chk(o_io_active, 1);
      chk(o_reset_output_pin_n, 1);
   endtask
   initial begin
      logic [15:0] cfg;
      void'($urandom(32'h47fa6c86));
      repeat (6) @(posedge i_clock);
      i_reset_n <= 1'b1;
      wait_fetch(16'hffff);
      $display("power-up release done");
      // pass 0 starts from the init phase left by power-up, pass 1 from normal running
      for (k = 0; k < 2; k++) begin
         cfg = 16'($urandom);
         d = 5 + ($urandom % 6);
         i_startup_config_port <= cfg;
         i_access_busy <= 1'b1;
         hold_low <= 1'b1;
         pulses = 0;
         for (n = 0; n < d; n++) begin
            @(posedge i_clock);
            pulses += o_cancel_holds;
         end
         chk(pulses, 1);
         chk(o_reset_input_pin_oe, 0);
         i_access_busy <= 1'b0; // running access ends inside the drain
         hold_low <= (k == 1);
         n = 0;
         while (!o_reset_input_pin_oe && n < 50) begin @(posedge i_clock); n++; end
         chk(i_reset_input_pin, 0);
         chk(o_reset_input_pin_out, 0);
         n = 0;
         while (o_reset_input_pin_oe) begin
            // end-of-init and pin enable are refused while the sequence runs
            i_io_enable_write <= (n == 100);
            i_end_of_init_instruction <= (n == 100);
            @(posedge i_clock);
            n++;
         end
         chk(n, 512);
         if (k == 1) begin
            repeat (20) @(posedge i_clock);
            chk(o_internal_reset, 1);
            chk(o_config_pullup_en, 1);
            hold_low <= 1'b0;
         end
         wait_fetch(cfg);
         end_init();
         $display("warm reset pass %0d done", k);
      end
      final_report();
   end
endmodule // tb
`default_nettype wire
